// ---- isa_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ISA_MAP_SVH
`define ISA_MAP_SVH

// Byte addresses of the word registers
`define ISA_OFF_CTRL 8'h00
`define ISA_OFF_FLAG 8'h04
`define ISA_OFF_IRQ_STAT 8'h08
`define ISA_OFF_IRQ_MASK 8'h0C
`define ISA_OFF_HOLD 8'h10
`define ISA_OFF_STATUS 8'h14

// bus_control_0 fields
`define ISA_CTRL_STOP 0
`define ISA_CTRL_START 1
`define ISA_CTRL_ACKE 2
`define ISA_CTRL_EXIT 6
`define ISA_CTRL_EN 7

// bus_flag_register fields
`define ISA_FLAG_RSV_DIS 0
`define ISA_FLAG_BUSY 6
`define ISA_FLAG_FAIL 7

// Interrupt status and mask fields
`define ISA_IRQ_DONE 0
`define ISA_IRQ_FAIL 1
`define ISA_IRQ_ARB 2
`define ISA_IRQ_STOP 3
`define ISA_IRQ_W 4

// Reset values
`define ISA_CTRL_RST 8'h00
`define ISA_FLAG_RST 8'h00
`define ISA_MASK_RST 4'h0

// Start hold time: 4000 ns at a 10 ns clock, rounded up
`define ISA_HOLD_NS 4000
`define ISA_CLK_NS 10
`define ISA_HOLD_CYC ((`ISA_HOLD_NS + `ISA_CLK_NS - 1) / `ISA_CLK_NS)

`endif

// ---- isa_pkg.sv ----
// Types shared by the start trigger and acknowledge control block
`default_nettype none

package isa_pkg;

    // Sampled or driven open-drain bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } isa_lines_type;

    // Latched AHB address phase
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } isa_aphase_type;

    // Start and restart sequencer
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_SDA,
        ST_START_HOLD,
        ST_OWN_WAIT,
        ST_RS_SDA_UP,
        ST_RS_SCL_UP
    } isa_state_type;

endpackage : isa_pkg

`default_nettype wire

// ---- isa_sync.sv ----
// Two flip-flop synchroniser with a chosen reset value
`timescale 1ns/100ps
`default_nettype none

module isa_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_ni,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule : isa_sync

`default_nettype wire

// ---- isa_start_ack_ctrl.sv ----
// Start trigger, start reservation and acknowledge control with AHB-Lite
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "isa_map.svh"

module isa_start_ack_ctrl #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Open-drain bus lines
    input wire logic bus_clock_line_i,
    input wire logic bus_data_line_i,
    output logic bus_clock_line_o,
    output logic bus_clock_line_oe_o,
    output logic bus_data_line_o,
    output logic bus_data_line_oe_o,
    // From the shift path and address matcher, same clock
    input wire logic arb_lost_i,
    input wire logic addr_phase_i,
    input wire logic ext_code_i,
    input wire logic addr_match_i,
    input wire logic ack_slot_i,
    input wire logic master_wait_i,
    input wire logic handoff_i,
    // To the rest of the controller
    output logic stop_req_o,
    output logic master_o,
    output logic irq_o
);

    logic rst_n;
    isa_pkg::isa_lines_type pin_raw;
    isa_pkg::isa_lines_type pin_s;
    isa_pkg::isa_lines_type pin_prev_q;
    isa_pkg::isa_aphase_type aph_q;
    isa_pkg::isa_aphase_type aph_d;
    isa_pkg::isa_state_type state_q;
    isa_pkg::isa_state_type state_d;
    logic aph_vld_q, aph_vld_d;
    logic en_q, en_d, acke_q, acke_d, stt_q, stt_d;
    logic rsv_dis_q, rsv_dis_d, fail_q, fail_d;
    logic busy_q, busy_d, master_q, master_d;
    logic [`ISA_IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [`ISA_IRQ_W-1:0] irq_mask_q, irq_mask_d;
    logic [`ISA_IRQ_W-1:0] irq_set;
    logic [CNT_W-1:0] hold_q, hold_d, cnt_q, cnt_d;
    logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic stop_q, stop_d, irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_ctrl, wr_flag, wr_stat, wr_mask, wr_hold;
    logic start_seen, stop_seen, abort, ack_drive, ack_en_eff;

    // Reset release through two flip-flops
    isa_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk_i(clk_i),
        .rst_ni(rstn_i),
        .d_i(1'b1),
        .q_o(rst_n)
    );

    // Bus lines come from outside and are sampled twice before use
    assign pin_raw = '{scl: bus_clock_line_i, sda: bus_data_line_i};
    isa_sync #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
        .clk_i(clk_i),
        .rst_ni(rst_n),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    // Bus conditions seen on the synchronised lines
    assign start_seen = pin_s.scl && pin_prev_q.scl && pin_prev_q.sda
                        && !pin_s.sda;
    assign stop_seen = pin_s.scl && pin_prev_q.scl && !pin_prev_q.sda
                       && pin_s.sda;

    // Data phase write strobes
    assign wr_ctrl = aph_vld_q && aph_q.wr && aph_q.addr == `ISA_OFF_CTRL;
    assign wr_flag = aph_vld_q && aph_q.wr && aph_q.addr == `ISA_OFF_FLAG;
    assign wr_stat = aph_vld_q && aph_q.wr
                     && aph_q.addr == `ISA_OFF_IRQ_STAT;
    assign wr_mask = aph_vld_q && aph_q.wr
                     && aph_q.addr == `ISA_OFF_IRQ_MASK;
    assign wr_hold = aph_vld_q && aph_q.wr && aph_q.addr == `ISA_OFF_HOLD;

    // Ack enable is honoured only when enabled and outside a plain address
    assign ack_en_eff = en_q && acke_q
                        && !(addr_phase_i && !ext_code_i);
    assign ack_drive = ack_slot_i && en_q
                       && ((addr_phase_i && addr_match_i)
                           || ack_en_eff);

    // Lost arbitration, exit request or disable all drop the sequence
    assign abort = arb_lost_i || !en_q
                   || (wr_ctrl && hwdata_i[`ISA_CTRL_EXIT]);

    // AHB-Lite address phase capture and read data
    always_comb begin
        aph_vld_d = hsel_i && htrans_i[1] && hready_i;
        aph_d = '{wr: hwrite_i, addr: haddr_i};
        rdata_d = rdata_q;
        if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
            rdata_d = 32'h0000_0000;
            unique case (haddr_i)
                `ISA_OFF_CTRL: begin
                    // Trigger and exit bits always read as zero
                    rdata_d[`ISA_CTRL_EN] = en_q;
                    rdata_d[`ISA_CTRL_ACKE] = acke_q;
                    rdata_d[`ISA_CTRL_START] = 1'b0;
                end
                `ISA_OFF_FLAG: begin
                    rdata_d[`ISA_FLAG_FAIL] = fail_q;
                    rdata_d[`ISA_FLAG_BUSY] = busy_q;
                    rdata_d[`ISA_FLAG_RSV_DIS] = rsv_dis_q;
                end
                `ISA_OFF_IRQ_STAT: rdata_d[`ISA_IRQ_W-1:0] = irq_stat_q;
                `ISA_OFF_IRQ_MASK: rdata_d[`ISA_IRQ_W-1:0] = irq_mask_q;
                `ISA_OFF_HOLD: rdata_d[CNT_W-1:0] = hold_q;
                `ISA_OFF_STATUS: begin
                    rdata_d[2:0] = state_q;
                    rdata_d[3] = master_q;
                    rdata_d[4] = stt_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Control, sequencer and line drive next values
    always_comb begin
        en_d = en_q;
        acke_d = acke_q;
        stt_d = stt_q;
        rsv_dis_d = rsv_dis_q;
        fail_d = fail_q;
        hold_d = hold_q;
        busy_d = busy_q;
        master_d = master_q;
        state_d = state_q;
        cnt_d = cnt_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = 1'b0;
        stop_d = 1'b0;
        irq_set = '0;
        if (start_seen) begin
            busy_d = 1'b1;
        end
        if (stop_seen) begin
            busy_d = 1'b0;
            master_d = 1'b0;
            irq_set[`ISA_IRQ_STOP] = 1'b1;
        end
        if (wr_ctrl) begin
            en_d = hwdata_i[`ISA_CTRL_EN];
            acke_d = hwdata_i[`ISA_CTRL_ACKE];
            stop_d = hwdata_i[`ISA_CTRL_STOP] && hwdata_i[`ISA_CTRL_EN];
            // Trigger is accepted only with the block enabled
            if (hwdata_i[`ISA_CTRL_START] && en_q) begin
                stt_d = 1'b1;
                fail_d = 1'b0;
            end
        end
        if (wr_flag) begin
            rsv_dis_d = hwdata_i[`ISA_FLAG_RSV_DIS];
        end
        if (wr_hold) begin
            hold_d = hwdata_i[CNT_W-1:0];
        end
        unique case (state_q)
            isa_pkg::ST_IDLE: begin
                scl_oe_d = 1'b0;
                if (stt_q && en_q) begin
                    if (master_q && master_wait_i) begin
                        // Hold the clock low while data rises
                        scl_oe_d = 1'b1;
                        cnt_d = hold_q;
                        state_d = isa_pkg::ST_RS_SDA_UP;
                    end else if (!busy_q) begin
                        // Free bus, or a held reservation now free
                        state_d = isa_pkg::ST_START_SDA;
                    end else if (!master_q && rsv_dis_q) begin
                        fail_d = 1'b1;
                        stt_d = 1'b0;
                        irq_set[`ISA_IRQ_FAIL] = 1'b1;
                    end
                end
            end
            isa_pkg::ST_START_SDA: begin
                // Data falls only while both lines are seen high
                if (pin_s.scl && pin_s.sda) begin
                    sda_oe_d = 1'b1;
                    cnt_d = hold_q;
                    state_d = isa_pkg::ST_START_HOLD;
                end
            end
            isa_pkg::ST_START_HOLD: begin
                sda_oe_d = 1'b1;
                if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    scl_oe_d = 1'b1;
                    stt_d = 1'b0;
                    master_d = 1'b1;
                    busy_d = 1'b1;
                    irq_set[`ISA_IRQ_DONE] = 1'b1;
                    state_d = isa_pkg::ST_OWN_WAIT;
                end else begin
                    cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            isa_pkg::ST_OWN_WAIT: begin
                sda_oe_d = 1'b1;
                if (stt_q) begin
                    cnt_d = hold_q;
                    state_d = isa_pkg::ST_RS_SDA_UP;
                end else if (handoff_i) begin
                    // Shift path now owns both lines
                    scl_oe_d = 1'b0;
                    state_d = isa_pkg::ST_IDLE;
                end
            end
            isa_pkg::ST_RS_SDA_UP: begin
                if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    scl_oe_d = 1'b0;
                    cnt_d = hold_q;
                    state_d = isa_pkg::ST_RS_SCL_UP;
                end else begin
                    cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            isa_pkg::ST_RS_SCL_UP: begin
                // Clock may be stretched by a slave; count only once high
                if (pin_s.scl) begin
                    if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        state_d = isa_pkg::ST_START_SDA;
                    end else begin
                        cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end
            default: state_d = isa_pkg::ST_IDLE;
        endcase
        if (abort) begin
            stt_d = 1'b0;
            master_d = 1'b0;
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
            state_d = isa_pkg::ST_IDLE;
            if (arb_lost_i) begin
                irq_set[`ISA_IRQ_ARB] = 1'b1;
            end
        end
        if (!en_q) begin
            fail_d = 1'b0;
            busy_d = 1'b0;
        end
        if (ack_drive) begin
            sda_oe_d = 1'b1;
        end
    end

    // Sticky interrupt status: a new event wins over a write-one clear
    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (wr_stat) begin
            irq_stat_d = irq_stat_q & ~hwdata_i[`ISA_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_set;
        if (wr_mask) begin
            irq_mask_d = hwdata_i[`ISA_IRQ_W-1:0];
        end
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    // All state registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aph_vld_q <= 1'b0;
            aph_q <= '0;
            rdata_q <= 32'h0000_0000;
            en_q <= 1'(`ISA_CTRL_RST >> `ISA_CTRL_EN);
            acke_q <= 1'b0;
            stt_q <= 1'b0;
            rsv_dis_q <= 1'b0;
            fail_q <= 1'b0;
            hold_q <= CNT_W'(`ISA_HOLD_CYC);
            cnt_q <= '0;
            busy_q <= 1'b0;
            master_q <= 1'b0;
            state_q <= isa_pkg::ST_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            stop_q <= 1'b0;
            irq_stat_q <= '0;
            irq_mask_q <= `ISA_MASK_RST;
            irq_q <= 1'b0;
            pin_prev_q <= 2'b11;
        end else begin
            aph_vld_q <= aph_vld_d;
            aph_q <= aph_d;
            rdata_q <= rdata_d;
            en_q <= en_d;
            acke_q <= acke_d;
            stt_q <= stt_d;
            rsv_dis_q <= rsv_dis_d;
            fail_q <= fail_d;
            hold_q <= hold_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            master_q <= master_d;
            state_q <= state_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            stop_q <= stop_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= irq_d;
            pin_prev_q <= pin_s;
        end
    end

    // Open drain: the pins only ever pull low
    assign bus_clock_line_o = 1'b0;
    assign bus_data_line_o = 1'b0;
    assign bus_clock_line_oe_o = scl_oe_q;
    assign bus_data_line_oe_o = sda_oe_q;
    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_q;
    assign stop_req_o = stop_q;
    assign master_o = master_q;
    assign irq_o = irq_q;

endmodule : isa_start_ack_ctrl

`default_nettype wire

// ---- isa_props.sv ----
// Port-level checks of start generation and acknowledge control
`timescale 1ns/100ps
`default_nettype none
`include "isa_map.svh"
module isa_props #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic bus_clock_line_i,
    input wire logic bus_clock_line_oe_o,
    input wire logic bus_data_line_oe_o,
    input wire logic arb_lost_i,
    input wire logic addr_phase_i,
    input wire logic ext_code_i,
    input wire logic addr_match_i,
    input wire logic ack_slot_i,
    input wire logic master_o
);
    logic ap_v_q, ap_w_q, en_q, acke_q, wr_c, rd_c, wr_h;
    logic [7:0] ap_a_q;
    logic [CNT_W-1:0] hold_q, cnt_q;
    // Data phase decode of the control and hold registers
    assign wr_c = ap_v_q && ap_w_q && ap_a_q == `ISA_OFF_CTRL;
    assign rd_c = ap_v_q && !ap_w_q && ap_a_q == `ISA_OFF_CTRL;
    assign wr_h = ap_v_q && ap_w_q && ap_a_q == `ISA_OFF_HOLD;
    // Shadow copy, since the ports do not show the enable bits
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ap_v_q <= 1'b0;
            ap_w_q <= 1'b0;
            ap_a_q <= 8'h00;
            en_q <= 1'b0;
            acke_q <= 1'b0;
            hold_q <= CNT_W'(`ISA_HOLD_CYC);
            cnt_q <= '0;
        end else begin
            if (hready_i) begin
                ap_v_q <= hsel_i && htrans_i[1];
                ap_w_q <= hwrite_i;
                ap_a_q <= haddr_i;
            end
            if (wr_c) begin
                en_q <= hwdata_i[`ISA_CTRL_EN];
                acke_q <= hwdata_i[`ISA_CTRL_ACKE];
            end
            if (wr_h) begin
                hold_q <= hwdata_i[CNT_W-1:0];
            end
            // Cycles with data held low while the clock is still free
            if (bus_data_line_oe_o && !bus_clock_line_oe_o) begin
                cnt_q <= cnt_q + 1'b1;
            end else begin
                cnt_q <= '0;
            end
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    AST_ACK_MATCH: assert property (
        ack_slot_i && en_q && addr_phase_i && addr_match_i
        |=> bus_data_line_oe_o) else $error("matched address not acked");
    AST_ACK_ON: assert property (
        ack_slot_i && en_q && acke_q && !addr_phase_i
        |=> bus_data_line_oe_o) else $error("ack enabled but data free");
    AST_ACK_ADDR_OFF: assert property (
        ack_slot_i && addr_phase_i && !ext_code_i && !addr_match_i &&
        !master_o && !bus_data_line_oe_o && !bus_clock_line_oe_o
        |=> !bus_data_line_oe_o) else $error("ack in address transfer");
    AST_START_SHAPE: assert property (
        $rose(bus_data_line_oe_o) && !bus_clock_line_oe_o
        |-> bus_clock_line_i) else $error("data pulled with clock low");
    AST_HOLD_TIME: assert property (
        $rose(bus_clock_line_oe_o) && bus_data_line_oe_o
        |-> cnt_q >= hold_q && cnt_q <= hold_q + 2'd2)
        else $error("start hold time wrong");
    AST_MASTER_WAIT: assert property (
        $rose(master_o) |-> bus_clock_line_oe_o && bus_data_line_oe_o)
        else $error("master without clock held low");
    AST_ARB_CLEAR: assert property (
        arb_lost_i |-> ##[1:2] (!master_o && !bus_clock_line_oe_o))
        else $error("lines kept after arbitration loss");
    AST_EXIT_CLEAR: assert property (
        wr_c && hwdata_i[`ISA_CTRL_EXIT]
        |-> ##[1:2] (!master_o && !bus_clock_line_oe_o))
        else $error("lines kept after exit");
    AST_STT_READ_ZERO: assert property (
        rd_c |-> hrdata_o[`ISA_CTRL_START] == 1'b0)
        else $error("start trigger read as one");
    AST_OFF_QUIET: assert property (
        !en_q [*3] |-> !master_o && !bus_clock_line_oe_o &&
        !bus_data_line_oe_o) else $error("activity while disabled");
    // Main scenarios reached
    cover property ($rose(master_o));
    cover property (arb_lost_i && bus_data_line_oe_o);
    cover property (ack_slot_i && addr_phase_i && addr_match_i);
endmodule : isa_props
`default_nettype wire

// ---- isa_bus_peer.sv ----
// Other bus party: makes start and stop conditions on the shared lines
`timescale 1ns/100ps
`default_nettype none
module isa_bus_peer (
    input wire logic start_i,
    input wire logic stop_i,
    output logic scl_pull_o,
    output logic sda_pull_o
);
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    // Start, then two clocks at 160 ns; clock then stands low
    always @(posedge start_i) begin
        #3 sda_pull_o = 1'b1; // Clear of the sampling edge
        #80 scl_pull_o = 1'b1;
        repeat (2) begin
            #80 scl_pull_o = 1'b0;
            #80 scl_pull_o = 1'b1;
        end
    end
    // Clock low before data moves, so no false start is seen
    always @(posedge stop_i) begin
        #3 scl_pull_o = 1'b1; // Clear of the sampling edge
        #40 sda_pull_o = 1'b1;
        #40 scl_pull_o = 1'b0;
        #80 sda_pull_o = 1'b0;
    end
endmodule : isa_bus_peer
`default_nettype wire

// ---- isa_tb.sv ----
// Self-checking bench for start trigger and acknowledge control
`timescale 1ns/100ps
`default_nettype none
`include "isa_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic clk_i = 1'b0, rstn_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hready, scl, sda, scl_oe, sda_oe, p_scl, p_sda, master, irq, stop;
    logic p_go = 1'b0, p_end = 1'b0, arb = 1'b0, aph = 1'b0;
    logic ext = 1'b0, match = 1'b0, slot = 1'b0, hand = 1'b0;
    logic [2:0] st;
    logic [5:0] ack_tab [6];
    int fails = 0, total_checks = 0, cyc = 0;
    // Open-drain lines with pull-ups
    assign scl = !(scl_oe || p_scl);
    assign sda = !(sda_oe || p_sda);
    assign st = {master, scl_oe, sda_oe};
    always #5 clk_i = !clk_i;
    isa_start_ack_ctrl #(.CNT_W(16)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(), .hrdata_o(hrdata), .bus_clock_line_i(scl),
        .bus_data_line_i(sda), .bus_clock_line_o(),
        .bus_clock_line_oe_o(scl_oe), .bus_data_line_o(),
        .bus_data_line_oe_o(sda_oe), .arb_lost_i(arb),
        .addr_phase_i(aph), .ext_code_i(ext), .addr_match_i(match),
        .ack_slot_i(slot), .master_wait_i(1'b0), .handoff_i(hand),
        .stop_req_o(stop), .master_o(master), .irq_o(irq));
    isa_bus_peer i_peer (.start_i(p_go), .stop_i(p_end),
        .scl_pull_o(p_scl), .sda_pull_o(p_sda));
    // One AHB single transfer, waiting for hready in each phase
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic chk_rd(input string n, input logic [7:0] a,
            input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, rd & m)
    endtask : chk_rd
    // Wait a bounded time for {master, clock oe, data oe} under a mask
    task automatic wait_st(input logic [2:0] m, input logic [2:0] v,
            input int n);
        repeat (n) begin
            if ((st & m) === v) break;
            @(posedge clk_i);
        end
        #1;
        `CHK("lines", v, st & m)
    endtask : wait_st
    // Peer start or stop, then time for it to finish
    task automatic peer(input logic s);
        @(posedge clk_i);
        if (s) p_go <= 1'b1;
        else p_end <= 1'b1;
        @(posedge clk_i);
        p_go <= 1'b0;
        p_end <= 1'b0;
        repeat (60) @(posedge clk_i);
    endtask : peer
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        // {enable, ack enable, address, extension, match, expected}
        ack_tab = '{6'h31, 6'h20, 6'h38, 6'h3D, 6'h2B, 6'h10};
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_rd("ctrl", `ISA_OFF_CTRL, 32'hFF, 32'h0);
        chk_rd("flag", `ISA_OFF_FLAG, 32'hFF, 32'h0);
        chk_rd("hold", `ISA_OFF_HOLD, 32'hFFFF, 32'h190);
        chk_rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h02);
        repeat (20) @(posedge clk_i);
        wait_st(3'h7, 3'h0, 1);
        $display("test disabled start done");
        xfer(1'b1, `ISA_OFF_HOLD, 32'h4);
        xfer(1'b1, `ISA_OFF_IRQ_MASK, 32'hF);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h80);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h82);
        chk_rd("stt", `ISA_OFF_CTRL, 32'hFF, 32'h80);
        wait_st(3'h7, 3'h7, 50);
        chk_rd("trig", `ISA_OFF_STATUS, 32'h18, 32'h08);
        chk_rd("done", `ISA_OFF_IRQ_STAT, 32'hF, 32'h1);
        xfer(1'b1, `ISA_OFF_IRQ_STAT, 32'h1);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h82);
        wait_st(3'h1, 3'h0, 40);
        wait_st(3'h2, 3'h0, 40);
        wait_st(3'h7, 3'h7, 80);
        @(posedge clk_i);
        hand <= 1'b1;
        @(posedge clk_i);
        hand <= 1'b0;
        wait_st(3'h3, 3'h0, 5);
        xfer(1'b1, `ISA_OFF_CTRL, 32'hC0);
        wait_st(3'h7, 3'h0, 5);
        peer(1'b0);
        $display("test start and restart done");
        xfer(1'b1, `ISA_OFF_HOLD, 32'h28);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h82);
        wait_st(3'h1, 3'h1, 20);
        arb <= 1'b1;
        @(posedge clk_i);
        arb <= 1'b0;
        wait_st(3'h7, 3'h0, 3);
        chk_rd("trig", `ISA_OFF_STATUS, 32'h10, 32'h0);
        xfer(1'b1, `ISA_OFF_HOLD, 32'h4);
        peer(1'b0);
        $display("test arbitration loss done");
        peer(1'b1);
        chk_rd("busy", `ISA_OFF_FLAG, 32'hC1, 32'h40);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h82);
        repeat (20) @(posedge clk_i);
        wait_st(3'h7, 3'h0, 1);
        chk_rd("held", `ISA_OFF_STATUS, 32'h10, 32'h10);
        xfer(1'b1, `ISA_OFF_CTRL, 32'hC0);
        chk_rd("exit", `ISA_OFF_STATUS, 32'h10, 32'h0);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h82);
        peer(1'b0);
        wait_st(3'h7, 3'h7, 200);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h00);
        wait_st(3'h7, 3'h0, 5);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h80);
        peer(1'b0);
        $display("test reservation done");
        xfer(1'b1, `ISA_OFF_FLAG, 32'h01);
        peer(1'b1);
        xfer(1'b1, `ISA_OFF_CTRL, 32'h82);
        repeat (10) @(posedge clk_i);
        wait_st(3'h7, 3'h0, 1);
        chk_rd("fail", `ISA_OFF_FLAG, 32'hFF, 32'hC1);
        chk_rd("trig", `ISA_OFF_STATUS, 32'h10, 32'h0);
        chk_rd("irq", `ISA_OFF_IRQ_STAT, 32'h2, 32'h2);
        `CHK("irq_o", 1'b1, irq)
        xfer(1'b1, `ISA_OFF_IRQ_STAT, 32'hF);
        #1;
        `CHK("irq_o", 1'b0, irq)
        peer(1'b0);
        $display("test start failure done");
        foreach (ack_tab[i]) begin
            xfer(1'b1, `ISA_OFF_CTRL, {24'h0, ack_tab[i][5], 4'h0,
                ack_tab[i][4], 2'h0});
            aph <= ack_tab[i][3];
            ext <= ack_tab[i][2];
            match <= ack_tab[i][1];
            slot <= 1'b1;
            @(posedge clk_i);
            slot <= 1'b0;
            // Data pull stands for one cycle only
            #1;
            `CHK("ack", ack_tab[i][0], sda_oe)
            repeat (5) @(posedge clk_i);
        end
        xfer(1'b1, `ISA_OFF_CTRL, 32'h81);
        #1;
        `CHK("stop", 1'b1, stop)
        $display("test acknowledge done");
        tally_and_finish();
    end
endmodule : testbench
bind isa_start_ack_ctrl isa_props #(.CNT_W(CNT_W)) i_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o),
    .bus_clock_line_i(bus_clock_line_i),
    .bus_clock_line_oe_o(bus_clock_line_oe_o),
    .bus_data_line_oe_o(bus_data_line_oe_o), .arb_lost_i(arb_lost_i),
    .addr_phase_i(addr_phase_i), .ext_code_i(ext_code_i),
    .addr_match_i(addr_match_i), .ack_slot_i(ack_slot_i),
    .master_o(master_o));
`default_nettype wire
